// [prs_pkg.sv]
// Package: constants for the program counter and return stack block
package prs_pkg;

  // ==========================================================
  // Widths
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;

  // ==========================================================
  // Vectors
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] LOW_VECTOR = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] MEM_TOP_DEFAULT = 21'h01ffff;

  // ==========================================================
  // Register offsets on the software port
  localparam logic [3:0] REG_PC_LOW = 4'h0;
  localparam logic [3:0] REG_PC_HIGH_LATCH = 4'h1;
  localparam logic [3:0] REG_PC_UPPER_LATCH = 4'h2;
  localparam logic [3:0] REG_STACK_PTR = 4'h3;
  localparam logic [3:0] REG_TOP_LOW = 4'h4;
  localparam logic [3:0] REG_TOP_HIGH = 4'h5;
  localparam logic [3:0] REG_TOP_UPPER = 4'h6;
  localparam logic [3:0] REG_CONFIG_ONE_LO = 4'h8;
  localparam logic [3:0] REG_CONFIG_ONE_HI = 4'h9;
  localparam logic [3:0] REG_CONFIG_TWO_LO = 4'ha;
  localparam logic [3:0] REG_CONFIG_TWO_HI = 4'hb;
  localparam logic [3:0] REG_CONFIG_THREE_LO = 4'hc;
  localparam logic [3:0] REG_CONFIG_THREE_HI = 4'hd;

  // ==========================================================
  // Stack pointer register fields
  localparam int FULL_BIT = 7;
  localparam int UNDER_BIT = 6;
  localparam logic [4:0] SP_MAX = 5'h1f;
  localparam logic [4:0] SP_RESET = 5'h00;
  // Overflow-reset enable sits in bit 0 of config word one low byte
  localparam int OVF_RESET_EN_BIT = 0;
  localparam logic [2:0] CFG_WORDS = 3'h4;

  // Config copy sequencer states
  typedef enum logic [1:0] {PRS_CFG_READ, PRS_CFG_RUN} prs_cfg_state_t;

endpackage

// [prs_stack_mem.sv]
// Return stack storage: 31 entries, index 1..31, index 0 has no storage
`timescale 1ns/1ps
module prs_stack_mem #(
  parameter int DEPTH = 31,
  parameter int WIDTH = 21
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] wr_mask
);
  // Entry array in flip-flops
  logic [WIDTH-1:0] mem_r [1:DEPTH];
  logic [WIDTH-1:0] mem_nxt [1:DEPTH];

  // ==========================================================
  // Read: index zero reads zero, giving the underflow value
  always_comb
  begin
    rd_data = '0;
    if (rd_idx != 5'h00 && int'(rd_idx) <= DEPTH)
      rd_data = mem_r[rd_idx];
  end

  // ==========================================================
  // Masked write of one entry, others untouched
  always_comb
  begin
    for (int i = 1; i <= DEPTH; i++)
    begin
      mem_nxt[i] = mem_r[i];
      if (wr_en && int'(wr_idx) == i)
        mem_nxt[i] = (mem_r[i] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 1; i <= DEPTH; i++)
        mem_r[i] <= '0;
    end
    else
    begin
      for (int i = 1; i <= DEPTH; i++)
        mem_r[i] <= mem_nxt[i];
    end
  end
endmodule

// [prs_config_loader.sv]
// Reset-time copier of the top program words into configuration bytes
`timescale 1ns/1ps
module prs_config_loader #(
  parameter logic [20:0] MEM_TOP = 21'h01ffff
)(
  input wire logic clk,
  input wire logic reset_n,
  output logic [20:0] cfg_addr,
  output logic cfg_req,
  input wire logic [15:0] cfg_word,
  output logic [47:0] cfg_bytes,
  output logic cfg_done
);
  // Copy state
  prs_pkg::prs_cfg_state_t state_r, state_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [47:0] bytes_r, bytes_nxt;
  logic pend_r, pend_nxt;
  logic [20:0] addr_r, addr_nxt;           // Registered read address
  logic req_r, req_nxt;                    // Registered read request
  logic done_r, done_nxt;                  // Registered copy-done flag

  // ==========================================================
  // Words read in ascending order; word four is fetched but dropped
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    bytes_nxt = bytes_r;
    pend_nxt = 1'b0;
    case (state_r)
      prs_pkg::PRS_CFG_READ:
      begin
        if (pend_r)
        begin
          // Low byte at lower address, word one first
          if (idx_r < 3'h3)
            bytes_nxt[idx_r*16 +: 16] = cfg_word;
          idx_nxt = idx_r + 3'h1;
          if (idx_r == prs_pkg::CFG_WORDS - 3'h1)
            state_nxt = prs_pkg::PRS_CFG_RUN;
        end
        else
          pend_nxt = 1'b1;
      end
      prs_pkg::PRS_CFG_RUN: state_nxt = prs_pkg::PRS_CFG_RUN;
      default: state_nxt = prs_pkg::PRS_CFG_READ;
    endcase
    // Pins decoded from the next state so they leave flip-flops
    // Top four words reserved: top-7 upward
    addr_nxt = MEM_TOP - 21'h000007 + {17'h0, idx_nxt, 1'b0};
    req_nxt = (state_nxt == prs_pkg::PRS_CFG_READ);
    done_nxt = (state_nxt == prs_pkg::PRS_CFG_RUN);
  end

  // Register stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= prs_pkg::PRS_CFG_READ;
      idx_r <= 3'h0;
      bytes_r <= 48'h000000000001;
      pend_r <= 1'b0;
      addr_r <= MEM_TOP - 21'h000007;
      req_r <= 1'b1;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      bytes_r <= bytes_nxt;
      pend_r <= pend_nxt;
      addr_r <= addr_nxt;
      req_r <= req_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs straight from the registers
  assign cfg_addr = addr_r;
  assign cfg_req = req_r;
  assign cfg_bytes = bytes_r;
  assign cfg_done = done_r;
endmodule

// [prs_core.sv]
// Program counter, latches and return stack of the core
//
// Contract
// - 21-bit counter; above memory fetches read zero
// - Reset loads counter with vector zero
// - Interrupts vector to 0008h or 0018h
// - Top four program words hold configuration
// - Reset copies configuration words into registers
// - Configuration bytes ascending; fourth word reserved
// - Counter in three bytes, only low accessible
// - Low-byte write loads both latches into counter
// - Low-byte read copies upper bytes to latches
// - Bit zero forced low; step by two
// - Calls, gotos, branches load counter directly
// - Stack is 31 by 21, 5-bit pointer
// - Push on calls/interrupts; pop on returns
// - Calls and returns leave latches alone
// - Push increments first; pop reads then decrements
// - Pointer zero after reset, no entry zero
// - Top entry and pointer software accessible
// - Full flag after 31 pushes, software clears
// - Overflow reset stores, flags, resets, pointer zero
// - No overflow reset: pointer sticks at 31
// - Empty pop loads zero, sets underflow flag
// - Pointer register: full, underflow, zero, pointer
`timescale 1ns/1ps
module prs_core #(
  parameter logic [20:0] MEM_TOP = prs_pkg::MEM_TOP_DEFAULT
)(
  input wire logic clk,
  input wire logic reset_n,
  // Execution unit commands, one-cycle pulses
  input wire logic step,
  input wire logic jump,
  input wire logic [20:0] jump_addr,
  input wire logic call,
  input wire logic ret,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic ext_set_en,
  input wire logic link_ret,
  // Software register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Program memory side
  output logic [20:0] fetch_addr,
  output logic fetch_blank,
  output logic [20:0] cfg_addr,
  output logic cfg_req,
  input wire logic [15:0] cfg_word,
  output logic cfg_ready,
  output logic [47:0] config_bytes,
  output logic stack_reset_req
);
  // ==========================================================
  // State declarations
  logic [20:0] pc_r, pc_nxt;               // Program counter
  logic [7:0] pc_high_latch_r, pc_high_latch_nxt;
  logic [4:0] pc_upper_latch_r, pc_upper_latch_nxt;
  logic [4:0] sp_r, sp_nxt;                // Stack pointer value
  logic stack_full_flag_r, stack_full_flag_nxt;
  logic stack_underflow_flag_r, stack_underflow_flag_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic blank_r, blank_nxt;
  logic srst_r, srst_nxt;                  // Device reset request pulse
  logic soft_rst_r;                        // Delayed reset for counter
  logic [20:0] top_data;                   // Entry under the pointer
  logic st_wr;
  logic [4:0] st_idx;
  logic [20:0] st_data, st_mask;
  logic [47:0] cfg_bytes;
  logic cfg_done;
  logic ovf_reset_en;
  logic push;
  logic pop;
  logic [20:0] pc_plus;

  // ==========================================================
  // Submodules
  // Stack storage
  prs_stack_mem #(.DEPTH(prs_pkg::STACK_DEPTH), .WIDTH(prs_pkg::PC_W)) u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .rd_idx(sp_r),
    .rd_data(top_data),
    .wr_en(st_wr),
    .wr_idx(st_idx),
    .wr_data(st_data),
    .wr_mask(st_mask)
  );

  // Configuration copy after reset
  prs_config_loader #(.MEM_TOP(MEM_TOP)) u_cfg (
    .clk(clk),
    .reset_n(reset_n),
    .cfg_addr(cfg_addr),
    .cfg_req(cfg_req),
    .cfg_word(cfg_word),
    .cfg_bytes(cfg_bytes),
    .cfg_done(cfg_done)
  );

  // Overflow-reset enable from config word one, default set
  assign ovf_reset_en = cfg_bytes[prs_pkg::OVF_RESET_EN_BIT];
  // Link returns pop only with the extended set enabled
  assign push = call | irq_high | irq_low;
  assign pop = ret | (link_ret & ext_set_en);
  // Return address: next sequential word
  assign pc_plus = pc_r + prs_pkg::PC_STEP;

  // ==========================================================
  // Next-state logic: counter, latches, stack, flags
  // Priority: device reset, interrupt, push, pop, jump, sw, step
  always_comb
  begin
    pc_nxt = pc_r;
    pc_high_latch_nxt = pc_high_latch_r;
    pc_upper_latch_nxt = pc_upper_latch_r;
    sp_nxt = sp_r;
    stack_full_flag_nxt = stack_full_flag_r;
    stack_underflow_flag_nxt = stack_underflow_flag_r;
    srst_nxt = 1'b0;
    st_wr = 1'b0;
    st_idx = sp_r;
    st_data = '0;
    st_mask = '0;
    rdata_nxt = 8'h00;

    // Software writes first so hardware events other than a step win after
    if (reg_wr)
    begin
      case (reg_addr)
        prs_pkg::REG_PC_LOW:
          // Latches move into counter, bit 0 kept clear
          pc_nxt = {pc_upper_latch_r, pc_high_latch_r, reg_wdata[7:1], 1'b0};
        prs_pkg::REG_PC_HIGH_LATCH: pc_high_latch_nxt = reg_wdata;
        prs_pkg::REG_PC_UPPER_LATCH: pc_upper_latch_nxt = reg_wdata[4:0];
        prs_pkg::REG_STACK_PTR:
        begin
          // Flags clear-only by software, pointer writable
          sp_nxt = reg_wdata[4:0];
          if (!reg_wdata[prs_pkg::FULL_BIT])
            stack_full_flag_nxt = 1'b0;
          if (!reg_wdata[prs_pkg::UNDER_BIT])
            stack_underflow_flag_nxt = 1'b0;
        end
        prs_pkg::REG_TOP_LOW:
        begin
          // Patch pointed entry only
          st_wr = 1'b1;
          st_data = {13'h0, reg_wdata};
          st_mask = 21'h0000ff;
        end
        prs_pkg::REG_TOP_HIGH:
        begin
          st_wr = 1'b1;
          st_data = {5'h0, reg_wdata, 8'h00};
          st_mask = 21'h00ff00;
        end
        prs_pkg::REG_TOP_UPPER:
        begin
          st_wr = 1'b1;
          st_data = {reg_wdata[4:0], 16'h0000};
          st_mask = 21'h1f0000;
        end
        default: ;
      endcase
    end

    // Reads: low byte copies upper bytes to latches
    if (reg_rd)
    begin
      case (reg_addr)
        prs_pkg::REG_PC_LOW:
        begin
          rdata_nxt = pc_r[7:0];
          pc_high_latch_nxt = pc_r[15:8];
          pc_upper_latch_nxt = pc_r[20:16];
        end
        prs_pkg::REG_PC_HIGH_LATCH: rdata_nxt = pc_high_latch_r;
        prs_pkg::REG_PC_UPPER_LATCH: rdata_nxt = {3'h0, pc_upper_latch_r};
        // Bit 5 reads zero
        prs_pkg::REG_STACK_PTR:
          rdata_nxt = {stack_full_flag_r, stack_underflow_flag_r, 1'b0, sp_r};
        prs_pkg::REG_TOP_LOW: rdata_nxt = top_data[7:0];
        prs_pkg::REG_TOP_HIGH: rdata_nxt = top_data[15:8];
        prs_pkg::REG_TOP_UPPER: rdata_nxt = {3'h0, top_data[20:16]};
        prs_pkg::REG_CONFIG_ONE_LO: rdata_nxt = cfg_bytes[7:0];
        prs_pkg::REG_CONFIG_ONE_HI: rdata_nxt = cfg_bytes[15:8];
        prs_pkg::REG_CONFIG_TWO_LO: rdata_nxt = cfg_bytes[23:16];
        prs_pkg::REG_CONFIG_TWO_HI: rdata_nxt = cfg_bytes[31:24];
        prs_pkg::REG_CONFIG_THREE_LO: rdata_nxt = cfg_bytes[39:32];
        prs_pkg::REG_CONFIG_THREE_HI: rdata_nxt = cfg_bytes[47:40];
        default: rdata_nxt = 8'h00;
      endcase
    end

    // Core updates; latches untouched here
    if (!cfg_done)
      pc_nxt = prs_pkg::RESET_VECTOR;
    else if (soft_rst_r)
      pc_nxt = prs_pkg::RESET_VECTOR;   // Stack overflow reset
    else if (push)
    begin
      // Increment first, then write next address
      if (sp_r == prs_pkg::SP_MAX)
      begin
        // Pointer held, entry 31 untouched
        stack_full_flag_nxt = 1'b1;
        sp_nxt = prs_pkg::SP_MAX;     // Push outranks a pointer write
      end
      else
      begin
        sp_nxt = sp_r + 5'h01;
        st_wr = 1'b1;
        st_idx = sp_r + 5'h01;
        st_data = pc_plus;
        st_mask = '1;
        if (sp_r + 5'h01 == prs_pkg::SP_MAX)
        begin
          stack_full_flag_nxt = 1'b1;
          if (ovf_reset_en)
          begin
            // Store PC+2, flag, reset device, pointer zero
            sp_nxt = prs_pkg::SP_RESET;
            srst_nxt = 1'b1;
          end
        end
      end
      // Vector or call target
      if (irq_high)
        pc_nxt = prs_pkg::HIGH_VECTOR;
      else if (irq_low)
        pc_nxt = prs_pkg::LOW_VECTOR;
      else
        pc_nxt = {jump_addr[20:1], 1'b0};
    end
    else if (pop)
    begin
      // Read pointed entry then decrement; empty pops zero
      pc_nxt = {top_data[20:1], 1'b0};
      if (sp_r == prs_pkg::SP_RESET)
      begin
        stack_underflow_flag_nxt = 1'b1;
        sp_nxt = prs_pkg::SP_RESET;   // Pop outranks a pointer write
      end
      else
        sp_nxt = sp_r - 5'h01;
    end
    else if (jump)
      pc_nxt = {jump_addr[20:1], 1'b0};   // Direct load
    else if (step && !(reg_wr && reg_addr == prs_pkg::REG_PC_LOW))
      pc_nxt = pc_plus;                   // Word step; low-byte write wins
  end

  // ==========================================================
  // Registers; flags survive stack-overflow reset, clear on POR
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_r <= prs_pkg::RESET_VECTOR;
      pc_high_latch_r <= 8'h00;
      pc_upper_latch_r <= 5'h00;
      sp_r <= prs_pkg::SP_RESET;
      stack_full_flag_r <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
      rdata_r <= 8'h00;
      blank_r <= 1'b0;
      srst_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end
    else
    begin
      pc_r <= pc_nxt;
      pc_high_latch_r <= pc_high_latch_nxt;
      pc_upper_latch_r <= pc_upper_latch_nxt;
      sp_r <= sp_nxt;
      stack_full_flag_r <= stack_full_flag_nxt;
      stack_underflow_flag_r <= stack_underflow_flag_nxt;
      rdata_r <= rdata_nxt;
      blank_r <= blank_nxt;
      srst_r <= srst_nxt;
      soft_rst_r <= srst_nxt;
    end
  end

  // Beyond implemented memory the fetch reads as zero
  assign blank_nxt = (pc_nxt > MEM_TOP);

  assign reg_rdata = rdata_r;
  assign fetch_addr = pc_r;
  assign fetch_blank = blank_r;
  assign cfg_ready = cfg_done;
  assign config_bytes = cfg_bytes;
  assign stack_reset_req = srst_r;

  // ==========================================================
  // Assertions
  property p_align;
    @(posedge clk) disable iff (!reset_n) pc_r[0] == 1'b0;
  endproperty
  a_align: assert property (p_align) else $error("counter misaligned");

  property p_step;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && step && !push && !pop && !jump && !reg_wr
      |=> pc_r == $past(pc_r) + 21'h000002;
  endproperty
  a_step: assert property (p_step) else $error("step not by two");

  property p_vec_high;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && irq_high |=> pc_r == 21'h000008;
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("bad high vector");

  property p_vec_low;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && irq_low && !irq_high |=> pc_r == 21'h000018;
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("bad low vector");

  property p_push_sp;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && push && sp_r < 5'h1e
      |=> sp_r == $past(sp_r) + 5'h01 && top_data == $past(pc_plus);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push mismatch");

  property p_underflow;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && !push && pop && sp_r == 5'h00
      |=> stack_underflow_flag_r && sp_r == 5'h00 && pc_r == 21'h000000;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow wrong");

  property p_overflow;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && push && sp_r == 5'h1e && ovf_reset_en
      |=> stack_full_flag_r && sp_r == 5'h00 && stack_reset_req
      ##1 pc_r == 21'h000000;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow reset wrong");

  property p_stick;
    @(posedge clk) disable iff (!reset_n)
      cfg_done && !soft_rst_r && push && sp_r == 5'h1f |=> sp_r == 5'h1f;
  endproperty
  a_stick: assert property (p_stick) else $error("pointer left 31");

  property p_latch;
    @(posedge clk) disable iff (!reset_n)
      (push || pop) && !reg_wr && !reg_rd
      |=> $stable(pc_high_latch_r) && $stable(pc_upper_latch_r);
  endproperty
  a_latch: assert property (p_latch) else $error("latch disturbed");

  c_call: cover property (@(posedge clk) disable iff (!reset_n) call ##[1:20] ret);
  c_full: cover property (@(posedge clk) disable iff (!reset_n) $rose(stack_full_flag_r));
  c_under: cover property (@(posedge clk) disable iff (!reset_n) $rose(stack_underflow_flag_r));
  c_pcl: cover property (@(posedge clk) disable iff (!reset_n) reg_wr && reg_addr == 4'h0);
endmodule

// [prs_mem_model.sv]
// Program memory model that answers the configuration copy reads
`timescale 1ns/1ps
module prs_mem_model #(
  parameter logic [20:0] MEM_TOP = 21'h00ffff
)(
  input wire logic clk,
  input wire logic ovf_en,
  input wire logic [20:0] cfg_addr,
  input wire logic cfg_req,
  output logic [15:0] cfg_word
);
  // ====
  // Read port
  // Each word carries its own address nibble, so a wrong fetch shows
  initial cfg_word = 16'h0000;
  // Answer one cycle after the address; the first word's bit 0 is
  // the overflow-reset enable. When idle the bus toggles, so a stale
  // word is never taken for a fresh one.
  always @(posedge clk)
  begin
    if (cfg_req)
    begin
      cfg_word <= {4'hc, cfg_addr[3:0], 4'h3, cfg_addr[3:1],
        (cfg_addr == MEM_TOP - 21'h000007) ? ovf_en : cfg_addr[0]};
    end
    else
    begin
      cfg_word <= ~cfg_word;
    end
  end
endmodule

// [prs_core_tb.sv]
// Self-checking bench for the program counter and return stack core
`timescale 1ns/1ps
module prs_core_tb;
  // ====
  // Signals
  localparam logic [20:0] TOP = 21'h00ffff; // 64-Kbyte part
  localparam logic [47:0] CFG_ON = 48'hcc3cca3ac839; // Words one to three, enable set
  localparam logic [47:0] CFG_OFF = 48'hcc3cca3ac838; // Same, enable clear
  logic clk, reset_n, ext_set_en, reg_wr, reg_rd, ovf_en;
  logic step, jump, call, ret, irq_high, irq_low, link_ret;
  logic fetch_blank, cfg_req, cfg_ready, stack_reset_req;
  logic [6:0] ops; // One-hot command pulses
  logic [20:0] jump_addr, fetch_addr, cfg_addr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] cfg_word;
  logic [47:0] config_bytes;
  int n_errors, cmp_count, cycles, i;
  assign {link_ret, irq_low, irq_high, ret, call, jump, step} = ops;

  prs_core #(.MEM_TOP(TOP)) u_dut (.clk(clk), .reset_n(reset_n), .step(step), .jump(jump),
    .jump_addr(jump_addr), .call(call), .ret(ret), .irq_high(irq_high), .irq_low(irq_low),
    .ext_set_en(ext_set_en), .link_ret(link_ret), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_addr(fetch_addr), .fetch_blank(fetch_blank), .cfg_addr(cfg_addr),
    .cfg_req(cfg_req), .cfg_word(cfg_word), .cfg_ready(cfg_ready),
    .config_bytes(config_bytes), .stack_reset_req(stack_reset_req));
  prs_mem_model #(.MEM_TOP(TOP)) u_mem (.clk(clk), .ovf_en(ovf_en), .cfg_addr(cfg_addr),
    .cfg_req(cfg_req), .cfg_word(cfg_word));

  // ====
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ====
  // Tasks
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for the copy of the configuration words
  task automatic wait_ready();
    int k;
    k = 0;
    while (cfg_ready !== 1'b1 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    #1;
    check("cfg_ready", cfg_ready, 1'b1);
  endtask
  task automatic do_reset(input logic en);
    @(posedge clk);
    reset_n <= 1'b0;
    ovf_en <= en;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_ready();
  endtask
  // Op: 0 step, 1 jump, 2 call, 3 return, 4 high irq, 5 low irq, 6 link return
  task automatic cmd(input int op, input logic [20:0] a);
    @(posedge clk);
    ops <= 7'h01 << op;
    jump_addr <= a;
    @(posedge clk);
    ops <= 7'h00;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(name, reg_rdata, exp);
  endtask
  task automatic blank_at(input logic [20:0] a, input logic exp);
    cmd(1, a);
    @(posedge clk);
    #1;
    check("fetch_blank", fetch_blank, exp);
  endtask

  // ====
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    ops = 7'h00;
    jump_addr = 21'h000000;
    ext_set_en = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ovf_en = 1'b1;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    do_reset(1'b1);
    check("fetch_addr", fetch_addr, 21'h000000);
    check("config_bytes", config_bytes, CFG_ON);
    for (i = 0; i < 6; i++)
      rd("config_reg", 4'h8 + i[3:0], CFG_ON[8*i +: 8]);
    rd("stack_ptr", 4'h3, 8'h00);
    rd("unmapped", 4'h7, 8'h00);
    for (i = 0; i < 3; i++)
      cmd(0, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h000006);
    cmd(1, 21'h012340);
    check("fetch_addr", fetch_addr, 21'h012340);
    rd("pc_low", 4'h0, 8'h40);
    rd("high_latch", 4'h1, 8'h23);
    rd("upper_latch", 4'h2, 8'h01);
    wr(4'h1, 8'h45);
    wr(4'h2, 8'h0a);
    wr(4'h0, 8'h67);
    check("fetch_addr", fetch_addr, 21'h0a4566);
    // Latches set apart from the counter, so calls and returns show any touch
    wr(4'h1, 8'h77);
    wr(4'h2, 8'h03);
    cmd(2, 21'h000100);
    check("fetch_addr", fetch_addr, 21'h000100);
    rd("stack_ptr", 4'h3, 8'h01);
    rd("top_low", 4'h4, 8'h68);
    rd("top_high", 4'h5, 8'h45);
    rd("top_upper", 4'h6, 8'h0a);
    cmd(4, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h000008);
    cmd(5, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h000018);
    rd("stack_ptr", 4'h3, 8'h03);
    cmd(3, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h00000a);
    cmd(6, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h00000a);
    @(posedge clk);
    ext_set_en <= 1'b1;
    cmd(6, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h000102);
    cmd(3, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h0a4568);
    rd("high_latch", 4'h1, 8'h77);
    rd("upper_latch", 4'h2, 8'h03);
    // Pop of an empty stack
    cmd(3, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h000000);
    rd("stack_ptr", 4'h3, 8'h40);
    wr(4'h3, 8'h00);
    rd("stack_ptr", 4'h3, 8'h00);
    // Software patching of two entries, then a return through one
    // No command overlaps these stack accesses, as if interrupts were masked
    wr(4'h3, 8'h05);
    wr(4'h4, 8'h20);
    wr(4'h5, 8'h31);
    wr(4'h6, 8'h02);
    wr(4'h3, 8'h06);
    wr(4'h4, 8'h44);
    wr(4'h3, 8'h05);
    rd("top_low", 4'h4, 8'h20);
    rd("top_high", 4'h5, 8'h31);
    cmd(3, 21'h000000);
    check("fetch_addr", fetch_addr, 21'h023120);
    rd("stack_ptr", 4'h3, 8'h04);
    // Overflow with the reset enable set
    wr(4'h3, 8'h00);
    for (i = 0; i < 30; i++)
      cmd(2, 21'h000300);
    rd("stack_ptr", 4'h3, 8'h1e);
    cmd(1, 21'h000400);
    cmd(2, 21'h000500);
    check("stack_reset_req", stack_reset_req, 1'b1);
    @(posedge clk);
    #1;
    check("fetch_addr", fetch_addr, 21'h000000);
    wait_ready();
    rd("stack_ptr", 4'h3, 8'h80);
    wr(4'h3, 8'h1f);
    rd("top_low", 4'h4, 8'h02);
    rd("top_high", 4'h5, 8'h04);
    rd("stack_ptr", 4'h3, 8'h1f);
    // Fetch blanking, then overflow with the reset enable clear
    do_reset(1'b0);
    check("config_bytes", config_bytes, CFG_OFF);
    blank_at(21'h00fffe, 1'b0);
    blank_at(21'h010000, 1'b1);
    blank_at(21'h1ffffe, 1'b1);
    for (i = 0; i < 31; i++)
      cmd(2, 21'h000200);
    rd("stack_ptr", 4'h3, 8'h9f);
    cmd(0, 21'h000000);
    cmd(0, 21'h000000);
    cmd(2, 21'h000600);
    rd("stack_ptr", 4'h3, 8'h9f);
    rd("top_low", 4'h4, 8'h02);
    rd("top_high", 4'h5, 8'h02);
    conclude();
  end
endmodule
